// [verilog/fault_response_config.sv]
// Fault filtering, flag masking and output error reaction with APB registers.
// Assumes synchronous inputs, one pclk, updates given as an enable pulse.
module fault_response_config (
    input wire logic pclk,                // Clock
    input wire logic presetn,             // Async reset, active low
    input wire logic psel,                // APB select
    input wire logic penable,             // APB enable
    input wire logic pwrite,              // APB direction
    input wire logic [7:0] paddr,         // APB byte address
    input wire logic [31:0] pwdata,       // APB write data
    output logic [31:0] prdata,           // APB read data
    output logic pready,                  // APB ready
    output logic pslverr,                 // APB error
    input wire logic update,              // Angle update strobe
    input wire logic [11:0] cond_raw,     // Raw fault conditions
    input wire logic power_up_load,       // Copy nonvolatile to shadow
    input wire logic ov_pulse,            // Overvoltage entry trigger
    input wire logic func_pulse,          // Function pulse entry trigger
    input wire logic analog_event,        // Analog event seen
    input wire logic code_valid,          // Received code strobe
    input wire logic [15:0] code_word,    // Received code
    input wire logic analog_part,         // Part has analog output
    input wire logic margin_req,          // Margin test request
    output logic [11:0] flags,            // Reported flags
    output logic prog_active,             // Programming interface active
    output logic prog_accept,             // Programming traffic accepted
    output logic nvm_write_block,         // Nonvolatile writes refused
    output logic margin_test_en,          // Margin test allowed
    output logic ov_level_choice,         // Overvoltage threshold pick
    output logic uv_level_choice,         // Undervoltage threshold pick
    output logic [2:0] dac_span,          // DAC span code
    output logic driver_filter_wide,      // Driver filter 30 kHz
    output logic pwm_half_rate,           // PWM at half frequency
    output logic sent_report_flags,       // SENT reports flags
    output logic dig_oe,                  // Digital driver enable
    output logic ana_oe,                  // Analog driver enable
    output logic ana_force,               // Analog forced level
    output logic ana_forced,              // Analog override active
    output logic uv_report,               // Undervoltage reported digitally
    output logic rise_threshold_choice,   // Rising threshold pick
    output logic fall_threshold_choice    // Falling and overdrive threshold
);
    ////////////////////////////////////////////////////////////////////////
    logic [25:0] filt_q, nvm_q, shadow_q;
    logic entered_q, unlocked_q, event_seen_q, comm_dead_q;
    logic [6:0] rel_cnt_q;
    logic [7:0] uv_cnt_q;
    fault_cfg_pkg::ana_state_e ana_q;
    logic wr_en, rd_en, any_flag;
    logic [11:0] filtered;

    // Decode code of 0..n into 2^(n-1), with 0 mapping to 0
    function automatic logic [7:0] pow_code(input logic [2:0] c);
        pow_code = (c == 3'h0) ? 8'h00 : (8'h01 << (c - 3'h1));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !(paddr == fault_cfg_pkg::OFS_FILTER
        || paddr == fault_cfg_pkg::OFS_NVM || paddr == fault_cfg_pkg::OFS_SHADOW
        || paddr == fault_cfg_pkg::OFS_STATUS || paddr == fault_cfg_pkg::OFS_CTRL);

    // Filter and mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_q <= fault_cfg_pkg::CFG_RESET;
        end else if (wr_en && paddr == fault_cfg_pkg::OFS_FILTER) begin
            filt_q <= pwdata[25:0];
        end
    end

    // Nonvolatile copy; lock field refuses writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nvm_q <= fault_cfg_pkg::CFG_RESET;
        end else if (wr_en && paddr == fault_cfg_pkg::OFS_NVM && !nvm_write_block) begin
            nvm_q <= pwdata[25:0];
        end
    end
    assign nvm_write_block = |shadow_q[fault_cfg_pkg::MEM_LOCK_LSB +: 4];

    // Shadow copy, loaded at power-up; not writable once communication is dead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_q <= fault_cfg_pkg::CFG_RESET;
        end else if (power_up_load) begin
            shadow_q <= nvm_q;
        end else if (wr_en && paddr == fault_cfg_pkg::OFS_SHADOW && !comm_dead_q) begin
            shadow_q <= pwdata[25:0];
        end
    end

    // Read data, captured in the setup phase and held through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            unique case (paddr)
                fault_cfg_pkg::OFS_FILTER: prdata <= {6'h00, filt_q};
                fault_cfg_pkg::OFS_NVM: prdata <= {6'h00, nvm_q};
                fault_cfg_pkg::OFS_SHADOW: prdata <= {6'h00, shadow_q};
                fault_cfg_pkg::OFS_STATUS: prdata <= {20'h00000, flags};
                fault_cfg_pkg::OFS_CTRL: prdata <= {26'h0000000,
                    ana_q == fault_cfg_pkg::ANA_ERROR,
                    uv_report, comm_dead_q, unlocked_q, entered_q, prog_active};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Persistence filters for the filtered conditions
    logic [4:0] acf_lim, err_lim;
    assign acf_lim = 5'(pow_code({1'b0, filt_q[fault_cfg_pkg::ACF_FILT_LSB +: 2]}) << 1);
    assign err_lim = (filt_q[fault_cfg_pkg::ERR_FILT_LSB +: 3] > 3'h4) ? 5'h00 :
        5'(pow_code(filt_q[fault_cfg_pkg::ERR_FILT_LSB +: 3]) << 1);

    localparam int NF = 4;
    localparam int FIDX [NF] = '{fault_cfg_pkg::F_ACF, fault_cfg_pkg::F_AOC,
        fault_cfg_pkg::F_SAT, fault_cfg_pkg::F_SRR};
    persist_if pif [NF] ();
    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_filt
            assign pif[g].cond = cond_raw[FIDX[g]];
            assign pif[g].limit = (g == 0) ? acf_lim : err_lim;
            persist_filter u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .update(update),
                .p(pif[g])
            );
        end
    endgenerate

    // Merge filtered and direct conditions, then mask both reporting and the error reaction
    always_comb begin
        filtered = cond_raw;
        filtered[fault_cfg_pkg::F_ACF] = pif[0].flag;
        filtered[fault_cfg_pkg::F_AOC] = pif[1].flag;
        filtered[fault_cfg_pkg::F_SAT] = pif[2].flag;
        filtered[fault_cfg_pkg::F_SRR] = pif[3].flag;
    end
    assign flags = filtered & ~filt_q[11:0];
    assign any_flag = |flags;

    ////////////////////////////////////////////////////////////////////////
    // Analog error state with release hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ana_q <= fault_cfg_pkg::ANA_NORMAL;
            rel_cnt_q <= 7'h00;
        end else if (update) begin
            unique case (ana_q)
                fault_cfg_pkg::ANA_NORMAL: begin
                    if (any_flag) begin
                        ana_q <= fault_cfg_pkg::ANA_ERROR;
                    end
                end
                fault_cfg_pkg::ANA_ERROR, fault_cfg_pkg::ANA_RELEASE: begin
                    if (any_flag) begin
                        ana_q <= fault_cfg_pkg::ANA_RELEASE;
                        rel_cnt_q <= 7'h00;
                    end else if (rel_cnt_q + 7'h01 >=
                        7'(pow_code(shadow_q[fault_cfg_pkg::HOLD_LSB +: 3]))) begin
                        ana_q <= fault_cfg_pkg::ANA_NORMAL;
                        rel_cnt_q <= 7'h00;
                    end else begin
                        ana_q <= fault_cfg_pkg::ANA_RELEASE;
                        rel_cnt_q <= rel_cnt_q + 7'h01;
                    end
                end
            endcase
        end
    end

    // Analog output reaction while in error
    logic [1:0] ana_resp;
    assign ana_resp = shadow_q[fault_cfg_pkg::ANA_RESP_LSB +: 2];
    assign ana_forced = (ana_q != fault_cfg_pkg::ANA_NORMAL);
    assign ana_oe = !ana_forced || ana_resp == fault_cfg_pkg::ANA_HIGH
        || ana_resp == fault_cfg_pkg::ANA_LOW;
    assign ana_force = (ana_resp == fault_cfg_pkg::ANA_HIGH);

    // Digital output reaction
    assign dig_oe = !(shadow_q[fault_cfg_pkg::DIG_RESP_BIT] && any_flag);
    assign pwm_half_rate = !shadow_q[fault_cfg_pkg::DIG_RESP_BIT] && any_flag;
    assign sent_report_flags = !shadow_q[fault_cfg_pkg::DIG_RESP_BIT];

    // Undervoltage report hold: reloaded while the flag stands, counted down after.
    // Reloading every cycle keeps the report up with no gap when the flag falls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_cnt_q <= 8'h00;
        end else if (flags[fault_cfg_pkg::F_UV]) begin
            uv_cnt_q <= 8'h01 << shadow_q[fault_cfg_pkg::HOLD_LSB +: 3];
        end else if (update && uv_cnt_q != 8'h00) begin
            uv_cnt_q <= uv_cnt_q - 8'h01;
        end
    end
    assign uv_report = flags[fault_cfg_pkg::F_UV] || (uv_cnt_q != 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // Programming interface entry, gating and unlock
    logic entry_ok;
    always_comb begin
        unique case (shadow_q[fault_cfg_pkg::ENTRY_LSB +: 2])
            fault_cfg_pkg::ENTRY_BOTH: entry_ok = ov_pulse || func_pulse;
            fault_cfg_pkg::ENTRY_OV: entry_ok = ov_pulse;
            fault_cfg_pkg::ENTRY_PULSE: entry_ok = func_pulse;
            fault_cfg_pkg::ENTRY_NEVER: entry_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entered_q <= 1'b0;
            event_seen_q <= 1'b0;
            comm_dead_q <= 1'b0;
            unlocked_q <= 1'b0;
        end else begin
            if (shadow_q[fault_cfg_pkg::ENTRY_LSB +: 2] == fault_cfg_pkg::ENTRY_NEVER) begin
                comm_dead_q <= 1'b1;
                entered_q <= 1'b0;
            end else if (entry_ok) begin
                entered_q <= 1'b1;
            end
            if (analog_event) begin
                event_seen_q <= 1'b1;
            end
            if (code_valid && prog_active && code_word == fault_cfg_pkg::UNLOCK_CODE) begin
                unlocked_q <= 1'b1;
            end
        end
    end
    assign prog_active = entered_q && !comm_dead_q
        && (!shadow_q[fault_cfg_pkg::EVENT_GATE_BIT] || event_seen_q);
    assign prog_accept = prog_active && (!analog_part
        || !shadow_q[fault_cfg_pkg::PROG_LOCK_BIT] || unlocked_q);

    ////////////////////////////////////////////////////////////////////////
    // Straight configuration outputs from the shadow copy
    assign margin_test_en = margin_req && !shadow_q[fault_cfg_pkg::TEST_DIS_BIT];
    assign ov_level_choice = shadow_q[fault_cfg_pkg::OV_SEL_BIT];
    assign uv_level_choice = shadow_q[fault_cfg_pkg::UV_SEL_BIT];
    assign dac_span = shadow_q[fault_cfg_pkg::SPAN_LSB +: 3];
    assign driver_filter_wide = shadow_q[fault_cfg_pkg::BW_BIT];
    assign rise_threshold_choice = shadow_q[fault_cfg_pkg::RISE_BIT];
    assign fall_threshold_choice = shadow_q[fault_cfg_pkg::FALL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_mask_hides;
        @(posedge pclk) disable iff (!presetn)
            filt_q[fault_cfg_pkg::F_UV] |-> !flags[fault_cfg_pkg::F_UV];
    endproperty
    a_mask_hides: assert property (p_mask_hides) else $error("masked flag reported");

    property p_dig_hiz;
        @(posedge pclk) disable iff (!presetn)
            (shadow_q[fault_cfg_pkg::DIG_RESP_BIT] && any_flag) |-> !dig_oe && !pwm_half_rate;
    endproperty
    a_dig_hiz: assert property (p_dig_hiz) else $error("digital driver not released");

    property p_never_entry;
        @(posedge pclk) disable iff (!presetn) comm_dead_q |=> !prog_active && comm_dead_q;
    endproperty
    a_never_entry: assert property (p_never_entry) else $error("dead link revived");

    property p_nvm_lock;
        @(posedge pclk) disable iff (!presetn)
            nvm_write_block && !power_up_load |=> $stable(nvm_q);
    endproperty
    a_nvm_lock: assert property (p_nvm_lock) else $error("locked memory written");

    property p_unlock;
        @(posedge pclk) disable iff (!presetn)
            (analog_part && shadow_q[fault_cfg_pkg::PROG_LOCK_BIT] && !unlocked_q)
            |-> !prog_accept;
    endproperty
    a_unlock: assert property (p_unlock) else $error("accepted without unlock");

    property p_ana_error;
        @(posedge pclk) disable iff (!presetn) (update && any_flag) |=> ana_forced;
    endproperty
    a_ana_error: assert property (p_ana_error) else $error("analog not in error");

    property p_zero_filter;
        @(posedge pclk) disable iff (!presetn)
            (err_lim == 5'h00 && cond_raw[fault_cfg_pkg::F_SAT]) |-> pif[2].flag;
    endproperty
    a_zero_filter: assert property (p_zero_filter) else $error("unfiltered flag late");

    property p_uv_hold;
        @(posedge pclk) disable iff (!presetn)
            $fell(flags[fault_cfg_pkg::F_UV]) |-> uv_report;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("undervoltage report dropped");

    property p_margin_block;
        @(posedge pclk) disable iff (!presetn)
            shadow_q[fault_cfg_pkg::TEST_DIS_BIT] |-> !margin_test_en;
    endproperty
    a_margin_block: assert property (p_margin_block) else $error("margin test not blocked");

    property p_event_gate;
        @(posedge pclk) disable iff (!presetn)
            (shadow_q[fault_cfg_pkg::EVENT_GATE_BIT] && !event_seen_q) |-> !prog_active;
    endproperty
    a_event_gate: assert property (p_event_gate) else $error("link open before event");

    property p_release_restart;
        @(posedge pclk) disable iff (!presetn)
            (update && any_flag) |=> rel_cnt_q == 7'h00;
    endproperty
    a_release_restart: assert property (p_release_restart) else $error("hold run kept");
endmodule

// [verilog/fault_cfg_pkg.sv]
// Constants shared by the fault response configuration block.
// Assumes a single 200 MHz clock and an APB register port.
package fault_cfg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FILTER = 8'h38;
    localparam logic [7:0] OFS_NVM = 8'h3c;
    localparam logic [7:0] OFS_SHADOW = 8'h7c;
    localparam logic [7:0] OFS_STATUS = 8'h40;
    localparam logic [7:0] OFS_CTRL = 8'h44;
    localparam int CFG_W = 26;
    localparam int NUM_FLAGS = 12;
    // Filter register fields
    localparam int ACF_FILT_LSB = 15;
    localparam int ERR_FILT_LSB = 12;
    // Lock and output register fields
    localparam int PROG_LOCK_BIT = 25;
    localparam int MEM_LOCK_LSB = 21;
    localparam int ENTRY_LSB = 19;
    localparam int TEST_DIS_BIT = 18;
    localparam int OV_SEL_BIT = 17;
    localparam int UV_SEL_BIT = 16;
    localparam int SPAN_LSB = 10;
    localparam int BW_BIT = 9;
    localparam int DIG_RESP_BIT = 8;
    localparam int ANA_RESP_LSB = 6;
    localparam int HOLD_LSB = 3;
    localparam int EVENT_GATE_BIT = 2;
    localparam int RISE_BIT = 1;
    localparam int FALL_BIT = 0;
    // Flag indices, equal to the mask bit positions
    localparam int F_ACF = 0;
    localparam int F_AOC = 1;
    localparam int F_SAT = 3;
    localparam int F_SRR = 6;
    localparam int F_UV = 10;
    localparam logic [25:0] CFG_RESET = 26'h0000000;
    localparam logic [1:0] ENTRY_BOTH = 2'h0;
    localparam logic [1:0] ENTRY_OV = 2'h1;
    localparam logic [1:0] ENTRY_PULSE = 2'h2;
    localparam logic [1:0] ENTRY_NEVER = 2'h3;
    localparam logic [1:0] ANA_HIGH = 2'h1;
    localparam logic [1:0] ANA_LOW = 2'h2;
    // Arbitrary unlock code value
    localparam logic [15:0] UNLOCK_CODE = 16'ha5c3;
    typedef enum logic [1:0] {ANA_NORMAL, ANA_ERROR, ANA_RELEASE} ana_state_e;
endpackage

// [verilog/persist_if.sv]
// Carries one condition and its persistence threshold to a filter.
// Assumes the filter counts on pclk update strobes.
interface persist_if;
    logic cond;
    logic [4:0] limit;
    logic flag;
    modport ctl (output cond, output limit, input flag);
    modport filt (input cond, input limit, output flag);
endinterface

// [verilog/persist_filter.sv]
// Persistence filter raising a flag after a run of asserted updates.
// Assumes update is a one-cycle enable pulse on pclk.
module persist_filter (
    input wire logic pclk,    // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic update,  // Update strobe
    persist_if.filt p         // Condition in, flag out
);
    logic [4:0] cnt_q;

    // Count consecutive asserted updates; restart on a gap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 5'h00;
        end else if (update) begin
            if (!p.cond) begin
                cnt_q <= 5'h00;
            end else if (cnt_q < p.limit) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // Flag once the run reaches the limit; zero limit flags at once
    assign p.flag = p.cond && (cnt_q >= p.limit);
endmodule

// [tb/prog_partner.sv]
// Programmer model on the far side of the code input.
// Assumes the bench raises send for one cycle to transmit the unlock code.
module prog_partner (
    input wire logic pclk,        // Clock
    input wire logic presetn,     // Async reset, active low
    input wire logic send,        // Send unlock code
    output logic code_valid,      // Code strobe
    output logic [15:0] code_word // Code word
);
    timeunit 1ns;
    timeprecision 1ps;
    // Unlock code goes out first; between words the line inverts each cycle, so stale data matches every second cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_valid <= 1'b0;
            code_word <= 16'h0000;
        end else begin
            code_valid <= send;
            code_word <= send ? fault_cfg_pkg::UNLOCK_CODE : ~code_word;
        end
    end
endmodule

// [tb/test_fault_response_config.sv]
// Self-checking bench for the fault response configuration block.
// Assumes APB answers with pready and a programmer model on the code input.
module test_fault_response_config;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, update, power_up_load, er;
    logic ov_pulse, func_pulse, analog_event, code_valid, analog_part, margin_req, send;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [15:0] code_word;
    logic [11:0] cond_raw, flags;
    logic prog_active, prog_accept, nvm_write_block, margin_test_en, ov_level_choice;
    logic uv_level_choice, driver_filter_wide, pwm_half_rate, sent_report_flags, dig_oe;
    logic ana_oe, ana_force, ana_forced, uv_report, rise_threshold_choice, fall_threshold_choice;
    logic [2:0] dac_span;
    int n_fail, checks_done, k, c, b, lm;
    int lim [8] = '{0, 2, 4, 8, 16, 0, 0, 0};

    fault_response_config DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .update, .cond_raw, .power_up_load, .ov_pulse, .func_pulse,
        .analog_event, .code_valid, .code_word, .analog_part, .margin_req, .flags, .prog_active,
        .prog_accept, .nvm_write_block, .margin_test_en, .ov_level_choice, .uv_level_choice,
        .dac_span, .driver_filter_wide, .pwm_half_rate, .sent_report_flags, .dig_oe, .ana_oe,
        .ana_force, .ana_forced, .uv_report, .rise_threshold_choice, .fall_threshold_choice);
    prog_partner partner (.pclk, .presetn, .send, .code_valid, .code_word);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #100us;
        n_fail++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task test_done;
        $display("Checks %0d, errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task upd(input int n);
        repeat (n) begin
            @(posedge pclk);
            update <= 1'b1;
            @(posedge pclk);
            update <= 1'b0;
        end
        #1;
    endtask
    task setc(input logic [11:0] x);
        @(posedge pclk);
        cond_raw <= x;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, update, power_up_load, ov_pulse, func_pulse} = '0;
        {analog_event, analog_part, margin_req, send, paddr, pwdata, cond_raw} = '0;
        v = $urandom(32'h90a5);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(fault_cfg_pkg::OFS_FILTER, 32'h0);
        rdc(fault_cfg_pkg::OFS_NVM, 32'h0);
        rdc(fault_cfg_pkg::OFS_SHADOW, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
        // Random masks with no filtering
        repeat (4) begin
            v = $urandom & 32'hfff;
            wr(fault_cfg_pkg::OFS_FILTER, v);
            rdc(fault_cfg_pkg::OFS_FILTER, v);
            setc(12'($urandom));
            chk(flags, cond_raw & ~v[11:0]);
        end
        // Every persistence code on the analog check and saturation flags
        for (c = 0; c < 12; c++) begin
            b = c < 4 ? 0 : 3;
            lm = lim[c < 4 ? c : c - 4];
            setc(12'h0);
            upd(1);
            wr(fault_cfg_pkg::OFS_FILTER, c < 4 ? c << 15 : (c - 4) << 12);
            setc(12'h1 << b);
            for (k = 0; k <= lm + 1; k++) begin
                if (k > 0)
                    upd(1);
                chk(flags[b], k >= lm);
            end
        end
        // A gap restarts the count
        wr(fault_cfg_pkg::OFS_FILTER, 32'h2 << 15);
        setc(12'h1);
        upd(2);
        setc(12'h0);
        upd(1);
        setc(12'h1);
        upd(3);
        chk(flags[0], 1'b0);
        upd(1);
        chk(flags[0], 1'b1);
        setc(12'h0);
        // Shadow fields reach their outputs
        repeat (3) begin
            v = $urandom & 32'h0003fffb;
            wr(fault_cfg_pkg::OFS_SHADOW, v);
            rdc(fault_cfg_pkg::OFS_SHADOW, v);
            chk({ov_level_choice, uv_level_choice, dac_span, driver_filter_wide,
                rise_threshold_choice, fall_threshold_choice},
                {v[17], v[16], v[12:10], v[9], v[1:0]});
        end
        // Error reactions for each analog code, digital bit alternating
        for (c = 0; c < 4; c++) begin
            wr(fault_cfg_pkg::OFS_SHADOW, (c << 6) | ((c & 1) << 8) | (3 << 3));
            setc(12'h010);
            upd(1);
            chk({ana_oe, dig_oe, pwm_half_rate, sent_report_flags},
                {c == 1 || c == 2, c[0] == 0, c[0] == 0, c[0] == 0});
            if (c == 1 || c == 2)
                chk(ana_force, c == 1);
            setc(12'h0);
            for (k = 1; k <= 5; k++) begin
                upd(1);
                if (c == 1)
                    chk(ana_forced, k < 4);
            end
        end
        // Undervoltage report hold for every hold code
        for (c = 0; c < 8; c++) begin
            wr(fault_cfg_pkg::OFS_SHADOW, c << 3);
            setc(12'h400);
            upd(1);
            setc(12'h0);
            for (k = 0; k <= (1 << c); k++) begin
                chk(uv_report, k < (1 << c));
                upd(1);
            end
        end
        // Power-up copy, then memory lock
        wr(fault_cfg_pkg::OFS_SHADOW, 32'h0);
        v = $urandom & 32'h0003fffb;
        wr(fault_cfg_pkg::OFS_NVM, v);
        @(posedge pclk);
        power_up_load <= 1'b1;
        @(posedge pclk);
        power_up_load <= 1'b0;
        rdc(fault_cfg_pkg::OFS_SHADOW, v);
        wr(fault_cfg_pkg::OFS_SHADOW, 32'h1 << 21);
        chk(nvm_write_block, 1'b1);
        wr(fault_cfg_pkg::OFS_NVM, ~v & 32'h3ffffff);
        rdc(fault_cfg_pkg::OFS_NVM, v);
        // Programming lock and test-mode block; bench clears shadow bit over APB for margin test
        margin_req <= 1'b1;
        analog_part <= 1'b1;
        wr(fault_cfg_pkg::OFS_SHADOW, 32'h2040000);
        chk(margin_test_en, 1'b0);
        @(posedge pclk);
        func_pulse <= 1'b1;
        @(posedge pclk);
        func_pulse <= 1'b0;
        #1;
        chk(prog_accept, 1'b0);
        @(posedge pclk);
        send <= 1'b1;
        @(posedge pclk);
        send <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk(prog_accept, 1'b1);
        wr(fault_cfg_pkg::OFS_SHADOW, 32'h0);
        chk(margin_test_en, 1'b1);
        // Mid-run reset, then each entry method except never against each trigger
        for (c = 0; c < 3; c++) begin
            for (k = 0; k < 2; k++) begin
                @(posedge pclk);
                presetn <= 1'b0;
                @(posedge pclk);
                presetn <= 1'b1;
                wr(fault_cfg_pkg::OFS_SHADOW, c << 19);
                @(posedge pclk);
                ov_pulse <= k == 0;
                func_pulse <= k == 1;
                @(posedge pclk);
                ov_pulse <= 1'b0;
                func_pulse <= 1'b0;
                #1;
                chk(prog_active, c == 0 || c == k + 1);
            end
        end
        // Event gate closes the link until an analog event
        wr(fault_cfg_pkg::OFS_SHADOW, 32'h100004);
        chk(prog_active, 1'b0);
        @(posedge pclk);
        analog_event <= 1'b1;
        @(posedge pclk);
        analog_event <= 1'b0;
        #1;
        chk(prog_active, 1'b1);
        // Entry never: further writes and traffic ignored
        wr(fault_cfg_pkg::OFS_SHADOW, 32'h180000);
        wr(fault_cfg_pkg::OFS_SHADOW, 32'h0);
        rdc(fault_cfg_pkg::OFS_SHADOW, 32'h180000);
        chk(prog_accept, 1'b0);
        test_done;
    end
endmodule
